// ==== logic/ees_pkg.sv ====
// Constants shared by the serial EEPROM target logic.
// Assumes a 25 MHz system clock and a two-wire link sampled by it.
package ees_pkg;

	// ==========================================================
	// Array geometry and device address decode
	// ==========================================================
	localparam int ADDR_W = 16;
	localparam int PAGE_BITS = 7;
	localparam int DATA_W = 8;
	localparam int LINK_W = 6;
	localparam logic [3:0] TYPE_ARRAY = 4'ha;
	localparam logic [3:0] TYPE_ID = 4'hb;
	localparam int LOCK_SEL_BIT = 10;
	localparam int LOCK_DATA_BIT = 1;
	localparam logic [3:0] BITS_PER_WORD = 4'h8;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_HZ = 25000000;
	localparam int TWR_MS = 5;
	localparam int TWR_CYC = TWR_MS * (CLK_HZ / 1000);

	// ==========================================================
	// Register map and fields
	// ==========================================================
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CTRL_LINK_EN = 0;
	localparam logic CTRL_LINK_EN_RST = 1'b1;
	localparam int ST_BUSY = 0;
	localparam int ST_LOCKED = 1;
	localparam int ST_STANDBY = 2;
	localparam int ST_WPROT = 3;
	localparam logic [5:0] LINK_RST = 6'h30;

	// ==========================================================
	// Protocol states
	// ==========================================================
	typedef enum logic [2:0] {
		S_IDLE,
		S_DEV,
		S_AHI,
		S_ALO,
		S_WDAT,
		S_RDAT
	} ees_state_t;

endpackage : ees_pkg

// ==== logic/ees_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static with respect to the clock.
`timescale 1ns/100ps
module ees_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	// ==========================================================
	// Sampling chain
	// ==========================================================
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			meta_reg <= INIT;
			q_reg <= INIT;
		end
		else if (ce_i)
		begin
			meta_reg <= d_i;
			q_reg <= meta_reg;
		end
	end

	assign q_o = q_reg;

endmodule : ees_sync

// ==== logic/ees_mem.sv ====
// Byte memory with one write port and a registered read port.
// Assumes writes and reads are driven from the same clock.
`timescale 1ns/100ps
module ees_mem #(
	parameter int AW = 16,
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);

	// ==========================================================
	// Storage
	// ==========================================================
	logic [DW-1:0] mem [0:(1 << AW) - 1];
	logic [DW-1:0] rdata_reg;

	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (we_i)
				mem[waddr_i] <= wdata_i;
			rdata_reg <= mem[raddr_i];
		end
	end

	assign rdata_o = rdata_reg;

endmodule : ees_mem

// ==== logic/ees_i2c_slave.sv ====
// Two-wire serial EEPROM target: protocol engine, arrays, status.
// Assumes pins arrive asynchronously and a Wishbone master on CLK_I.
//
// Function
// RULE1: Data edge with clock high is a condition.
// RULE2: Falling data while clock high means start.
// RULE3: Rising data while clock high means stop.
// RULE4: Acknowledge each received byte on ninth clock.
// RULE5: Standby after reset, read stop, write end.
// RULE6: Start, nine clocks, start, stop recovers link.
// RULE7: Device address: type code plus select pins.
// RULE8: Last address bit picks read or write.
// RULE9: Write protect pin blocks array writes.
// RULE10: Byte write: two address bytes, data, stop.
// RULE11: Page write sends more bytes before stop.
// RULE12: Page write wraps within low seven bits.
// RULE13: No acknowledge while write cycle runs.
// RULE14: Identification page write uses its type code.
// RULE15: Locked identification page refuses data bytes; lock command bytes (address bit 10 set) are still acknowledged.
// RULE16: Lock command with data bit one set.
// RULE17: Address counter persists, read wraps at end.
// RULE18: Current read sends byte at counter.
// RULE19: Random read loads address by dummy write.
// RULE20: Master acknowledge continues sequential read.
// RULE21: Identification page read uses its type code.
// RULE22: Truncated identification write reports lock state.
// RULE23: Release data line unless driving zero.
`timescale 1ns/100ps
module ees_i2c_slave #(
	parameter int WRITE_CYCLES = ees_pkg::TWR_CYC
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic CE_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic [2:0] CHIP_SELECT_PINS_I,
	input wire logic WRITE_PROTECT_PIN_I,
	output logic BUSY_O,
	output logic STANDBY_O,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O
);

	localparam int BW = $clog2(WRITE_CYCLES + 1);
	localparam int AW = ees_pkg::ADDR_W;
	localparam int PB = ees_pkg::PAGE_BITS;

	// ==========================================================
	// Pin synchronisation and condition detection
	// ==========================================================
	logic [5:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] cs_s;
	logic scl_p_reg;
	logic sda_p_reg;

	ees_sync #(
		.W(ees_pkg::LINK_W),
		.INIT(ees_pkg::LINK_RST)
	) u_sync (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.ce_i(CE_I),
		.d_i({SCL_I, SDA_I, WRITE_PROTECT_PIN_I, CHIP_SELECT_PINS_I}),
		.q_o(pins_s)
	);

	assign scl_s = pins_s[5];
	assign sda_s = pins_s[4];
	assign wp_s = pins_s[3];
	assign cs_s = pins_s[2:0];

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			scl_p_reg <= 1'b1;
			sda_p_reg <= 1'b1;
		end
		else if (CE_I)
		begin
			scl_p_reg <= scl_s;
			sda_p_reg <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_s & ~scl_p_reg;
	assign scl_fall = ~scl_s & scl_p_reg;
	assign start_det = scl_s & scl_p_reg & sda_p_reg & ~sda_s; // RULE1 RULE2
	assign stop_det = scl_s & scl_p_reg & ~sda_p_reg & sda_s; // RULE1 RULE3

	// ==========================================================
	// State
	// ==========================================================
	ees_pkg::ees_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic ackph_reg, ackph_next;
	logic oe_reg, oe_next;
	logic rw_reg, rw_next;
	logic id_reg, id_next;
	logic mack_reg, mack_next;
	logic [AW-1:0] addr_reg, addr_next;
	logic pend_v_reg, pend_v_next;
	logic pend_id_reg, pend_id_next;
	logic [AW-1:0] pend_addr_reg, pend_addr_next;
	logic [7:0] pend_data_reg, pend_data_next;
	logic wrote_reg, wrote_next;
	logic lockp_reg, lockp_next;
	logic locked_reg, locked_next;
	logic busy_reg, busy_next;
	logic [BW-1:0] bcnt_reg, bcnt_next;
	logic standby_reg, standby_next;
	logic link_en_reg;
	logic commit;

	// ==========================================================
	// Memories
	// ==========================================================
	logic [7:0] arr_rdata;
	logic [7:0] id_rdata;
	logic [7:0] rdata;
	logic arr_we;
	logic id_we;

	assign arr_we = commit & ~pend_id_reg;
	assign id_we = commit & pend_id_reg;
	assign rdata = id_reg ? id_rdata : arr_rdata;

	ees_mem #(
		.AW(AW),
		.DW(ees_pkg::DATA_W)
	) u_array (
		.clk_i(CLK_I),
		.ce_i(CE_I),
		.we_i(arr_we),
		.waddr_i(pend_addr_reg),
		.wdata_i(pend_data_reg),
		.raddr_i(addr_reg),
		.rdata_o(arr_rdata)
	);

	ees_mem #(
		.AW(PB),
		.DW(ees_pkg::DATA_W)
	) u_idpage (
		.clk_i(CLK_I),
		.ce_i(CE_I),
		.we_i(id_we),
		.waddr_i(pend_addr_reg[PB-1:0]),
		.wdata_i(pend_data_reg),
		.raddr_i(addr_reg[PB-1:0]),
		.rdata_o(id_rdata)
	);

	// ==========================================================
	// Decode helpers
	// ==========================================================
	logic type_ok;
	logic dev_ack;
	logic byte_end;
	logic ack_end;
	logic lock_cmd;
	logic [AW-1:0] page_inc;
	logic [AW-1:0] read_inc;

	assign type_ok = (sh_reg[7:4] == ees_pkg::TYPE_ARRAY) |
		(sh_reg[7:4] == ees_pkg::TYPE_ID); // RULE7 RULE14 RULE21
	assign dev_ack = type_ok & (sh_reg[3:1] == cs_s) & ~busy_reg; // RULE7 RULE13
	assign byte_end = scl_fall & ~ackph_reg &
		(cnt_reg == ees_pkg::BITS_PER_WORD);
	assign ack_end = scl_fall & ackph_reg;
	assign lock_cmd = id_reg & addr_reg[ees_pkg::LOCK_SEL_BIT]; // RULE16
	assign page_inc = {addr_reg[AW-1:PB], addr_reg[PB-1:0] + 7'h1}; // RULE12
	assign read_inc = id_reg ? page_inc : addr_reg + 16'h1; // RULE17 RULE21

	// ==========================================================
	// Protocol engine
	// ==========================================================
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		ackph_next = ackph_reg;
		oe_next = oe_reg;
		rw_next = rw_reg;
		id_next = id_reg;
		mack_next = mack_reg;
		addr_next = addr_reg;
		pend_v_next = pend_v_reg;
		pend_id_next = pend_id_reg;
		pend_addr_next = pend_addr_reg;
		pend_data_next = pend_data_reg;
		wrote_next = wrote_reg;
		lockp_next = lockp_reg;
		locked_next = locked_reg;
		standby_next = standby_reg;
		commit = 1'b0;
		if (!link_en_reg)
		begin
			state_next = ees_pkg::S_IDLE;
			oe_next = 1'b0;
			ackph_next = 1'b0;
			cnt_next = 4'h0;
		end
		else if (start_det)
		begin
			state_next = ees_pkg::S_DEV; // RULE2 RULE6
			cnt_next = 4'h0;
			ackph_next = 1'b0;
			oe_next = 1'b0;
			pend_v_next = 1'b0; // RULE22
			lockp_next = 1'b0;
			wrote_next = 1'b0;
			standby_next = 1'b0;
		end
		else if (stop_det)
		begin
			state_next = ees_pkg::S_IDLE; // RULE3 RULE6
			oe_next = 1'b0;
			ackph_next = 1'b0;
			commit = pend_v_reg; // RULE10 RULE11
			pend_v_next = 1'b0;
			wrote_next = 1'b0;
			lockp_next = 1'b0;
			locked_next = locked_reg | lockp_reg; // RULE16
			if (rw_reg)
				standby_next = 1'b1; // RULE3 RULE5
		end
		else
		begin
			unique case (state_reg)
				ees_pkg::S_IDLE:
				begin
					oe_next = 1'b0;
				end
				ees_pkg::S_DEV, ees_pkg::S_AHI, ees_pkg::S_ALO,
				ees_pkg::S_WDAT:
				begin
					if (scl_rise & ~ackph_reg &
						(cnt_reg != ees_pkg::BITS_PER_WORD))
					begin
						sh_next = {sh_reg[6:0], sda_s}; // RULE4
						cnt_next = cnt_reg + 4'h1;
					end
					if (byte_end)
					begin
						ackph_next = 1'b1;
						unique case (state_reg)
							ees_pkg::S_DEV:
							begin
								if (dev_ack)
								begin
									oe_next = 1'b1; // RULE4 RULE8
									rw_next = sh_reg[0]; // RULE8
									id_next = sh_reg[7:4] == ees_pkg::TYPE_ID;
								end
								else
								begin
									state_next = ees_pkg::S_IDLE; // RULE8 RULE13
									ackph_next = 1'b0;
									standby_next = 1'b1;
								end
							end
							ees_pkg::S_AHI:
							begin
								addr_next[15:8] = sh_reg; // RULE10 RULE19
								oe_next = 1'b1;
							end
							ees_pkg::S_ALO:
							begin
								addr_next[7:0] = sh_reg; // RULE10 RULE19
								oe_next = 1'b1;
							end
							default:
							begin
								if (lock_cmd)
								begin
									lockp_next = sh_reg[ees_pkg::LOCK_DATA_BIT]; // RULE16
									oe_next = 1'b1;
								end
								else if (id_reg & locked_reg)
									oe_next = 1'b0; // RULE15 RULE22
								else
								begin
									oe_next = 1'b1; // RULE11 RULE14 RULE22
									commit = pend_v_reg;
									wrote_next = wrote_reg | pend_v_reg;
									pend_v_next = id_reg | ~wp_s; // RULE9
									pend_id_next = id_reg;
									pend_addr_next = addr_reg;
									pend_data_next = sh_reg;
									addr_next = page_inc; // RULE12
								end
							end
						endcase
					end
					if (ack_end)
					begin
						ackph_next = 1'b0;
						cnt_next = 4'h0;
						oe_next = 1'b0; // RULE23
						unique case (state_reg)
							ees_pkg::S_DEV:
							begin
								if (rw_reg)
								begin
									state_next = ees_pkg::S_RDAT; // RULE18
									sh_next = rdata;
									oe_next = ~rdata[7];
									addr_next = read_inc; // RULE17
								end
								else
									state_next = ees_pkg::S_AHI;
							end
							ees_pkg::S_AHI: state_next = ees_pkg::S_ALO;
							default: state_next = ees_pkg::S_WDAT;
						endcase
					end
				end
				ees_pkg::S_RDAT:
				begin
					if (scl_rise & ~ackph_reg)
					begin
						sh_next = {sh_reg[6:0], 1'b0};
						cnt_next = cnt_reg + 4'h1;
					end
					if (scl_fall & ~ackph_reg)
					begin
						if (cnt_reg == ees_pkg::BITS_PER_WORD)
						begin
							oe_next = 1'b0; // RULE23
							ackph_next = 1'b1;
						end
						else
							oe_next = ~sh_reg[7]; // RULE23
					end
					if (scl_rise & ackph_reg)
						mack_next = ~sda_s; // RULE20
					if (ack_end)
					begin
						ackph_next = 1'b0;
						cnt_next = 4'h0;
						if (mack_reg)
						begin
							sh_next = rdata; // RULE20
							oe_next = ~rdata[7];
							addr_next = read_inc; // RULE17 RULE20
						end
						else
						begin
							oe_next = 1'b0; // RULE18 RULE20
							state_next = ees_pkg::S_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Self-timed write cycle
	// ==========================================================
	logic cycle_go;
	assign cycle_go = link_en_reg & stop_det & ~start_det &
		(pend_v_reg | wrote_reg | lockp_reg);

	always_comb
	begin
		busy_next = busy_reg;
		bcnt_next = bcnt_reg;
		if (cycle_go)
		begin
			busy_next = 1'b1; // RULE10 RULE13
			bcnt_next = BW'(WRITE_CYCLES);
		end
		else if (busy_reg)
		begin
			bcnt_next = bcnt_reg - {{(BW-1){1'b0}}, 1'b1};
			if (bcnt_reg == {{(BW-1){1'b0}}, 1'b1})
				busy_next = 1'b0; // RULE13
		end
	end

	// ==========================================================
	// State registers
	// ==========================================================
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			state_reg <= ees_pkg::S_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			ackph_reg <= 1'b0;
			oe_reg <= 1'b0;
			rw_reg <= 1'b0;
			id_reg <= 1'b0;
			mack_reg <= 1'b0;
			addr_reg <= 16'h0000;
		end
		else if (CE_I)
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			ackph_reg <= ackph_next;
			oe_reg <= oe_next;
			rw_reg <= rw_next;
			id_reg <= id_next;
			mack_reg <= mack_next;
			addr_reg <= addr_next;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			pend_v_reg <= 1'b0;
			pend_id_reg <= 1'b0;
			pend_addr_reg <= 16'h0000;
			pend_data_reg <= 8'h00;
			wrote_reg <= 1'b0;
			lockp_reg <= 1'b0;
			locked_reg <= 1'b0;
		end
		else if (CE_I)
		begin
			pend_v_reg <= pend_v_next;
			pend_id_reg <= pend_id_next;
			pend_addr_reg <= pend_addr_next;
			pend_data_reg <= pend_data_next;
			wrote_reg <= wrote_next;
			lockp_reg <= lockp_next;
			locked_reg <= locked_next;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			busy_reg <= 1'b0;
			bcnt_reg <= '0;
			standby_reg <= 1'b1; // RULE5
		end
		else if (CE_I)
		begin
			busy_reg <= busy_next;
			bcnt_reg <= bcnt_next;
			standby_reg <= standby_next | (busy_reg & ~busy_next); // RULE5
		end
	end

	// ==========================================================
	// Wishbone register slave
	// ==========================================================
	logic wb_req;
	logic wb_wr;
	logic [31:0] rd_mux;
	logic ack_reg;
	logic [31:0] dat_reg;

	assign wb_req = CYC_I & STB_I;
	assign wb_wr = wb_req & ack_reg & WE_I & SEL_I[0] &
		(ADR_I == ees_pkg::REG_CTRL);
	assign rd_mux =
		(ADR_I == ees_pkg::REG_CTRL) ? {31'h0, link_en_reg} :
		(ADR_I == ees_pkg::REG_STATUS) ?
		{28'h0, wp_s, standby_reg, locked_reg, busy_reg} : 32'h0;

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
			link_en_reg <= ees_pkg::CTRL_LINK_EN_RST;
		end
		else if (CE_I)
		begin
			ack_reg <= wb_req & ~ack_reg;
			if (wb_req & ~ack_reg)
				dat_reg <= rd_mux;
			if (wb_wr)
				link_en_reg <= DAT_I[ees_pkg::CTRL_LINK_EN];
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	logic sda_o_reg;
	logic sda_oe_reg;
	logic busy_o_reg;
	logic standby_o_reg;

	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			sda_o_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
			busy_o_reg <= 1'b0;
			standby_o_reg <= 1'b1;
		end
		else if (CE_I)
		begin
			sda_o_reg <= ~oe_next;
			sda_oe_reg <= oe_next; // RULE23
			busy_o_reg <= busy_next;
			standby_o_reg <= standby_next | (busy_reg & ~busy_next);
		end
	end

	assign SDA_O = sda_o_reg;
	assign SDA_OE_O = sda_oe_reg;
	assign BUSY_O = busy_o_reg;
	assign STANDBY_O = standby_o_reg;
	assign ACK_O = ack_reg;
	assign DAT_O = dat_reg;

endmodule : ees_i2c_slave

// ==== test/ees_checker.sv ====
// Port assertions for the serial EEPROM target.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module ees_checker #(
	parameter int WRITE_CYCLES = 50
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic SCL_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	input wire logic BUSY_O,
	input wire logic STANDBY_O,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O
);
	// ====================
	// Helper logic
	// ====================
	int busy_cnt;
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
			busy_cnt <= 0;
		else if (BUSY_O)
			busy_cnt <= busy_cnt + 1;
		else
			busy_cnt <= 0;
	end
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!NRST_I);
	// ====================
	// Assertions
	// ====================
	oe_low_only_a: assert property (SDA_OE_O |-> !SDA_O)
		else $error("data pin driven high");
	drive_clk_low_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
		else $error("data drive changed with clock high");
	drive_hold_a: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*6])
		else $error("low bit not held");
	standby_quiet_a: assert property (STANDBY_O |-> !SDA_OE_O)
		else $error("drive in standby");
	busy_quiet_a: assert property (BUSY_O |-> !SDA_OE_O)
		else $error("drive during write cycle");
	busy_length_a: assert property ($fell(BUSY_O) |-> busy_cnt == WRITE_CYCLES)
		else $error("write cycle length wrong");
	write_standby_a: assert property ($fell(BUSY_O) |-> ##[0:2] STANDBY_O)
		else $error("no standby after write cycle");
	reset_state_a: assert property (disable iff (1'b0)
		!NRST_I |=> STANDBY_O && !BUSY_O && !SDA_OE_O)
		else $error("wrong reset state");
	ack_pulse_a: assert property (ACK_O |=> !ACK_O)
		else $error("bus ack longer than one cycle");
	ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("bus ack missing");
	cover property ($fell(BUSY_O));
	cover property ($rose(SDA_OE_O));
	cover property (CYC_I && ACK_O);
endmodule : ees_checker

bind ees_i2c_slave ees_checker #(.WRITE_CYCLES(WRITE_CYCLES)) ees_checker_inst (
	.CLK_I(CLK_I), .NRST_I(NRST_I), .SCL_I(SCL_I), .SDA_O(SDA_O),
	.SDA_OE_O(SDA_OE_O), .BUSY_O(BUSY_O), .STANDBY_O(STANDBY_O),
	.CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O)
);

// ==== test/ees_master_model.sv ====
// Two-wire bus master model: clock and data pin drivers.
// Assumes the bench clock paces each bit at eight cycles.
`timescale 1ns/100ps
module ees_master_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// ====================
	// Pin drivers
	// ====================
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask : w
	task automatic xbit(input logic b, output logic r);
		sda_o <= b;
		w(2);
		scl_o <= 1'b1;
		w(3);
		r = sda_i;
		w(1);
		scl_o <= 1'b0;
		w(2);
	endtask : xbit
	task automatic start_c();
		sda_o <= 1'b1;
		w(2);
		scl_o <= 1'b1;
		w(4);
		sda_o <= 1'b0;
		w(4);
		scl_o <= 1'b0;
		w(2);
	endtask : start_c
	task automatic stop_c();
		sda_o <= 1'b0;
		w(2);
		scl_o <= 1'b1;
		w(4);
		sda_o <= 1'b1;
		w(4);
	endtask : stop_c
	task automatic wbyte(input logic [7:0] b, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(b[i], r);
		xbit(1'b1, a);
	endtask : wbyte
	task automatic rbyte(input logic nk, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			xbit(1'b1, r);
			d[i] = r;
		end
		xbit(nk, r);
	endtask : rbyte
endmodule : ees_master_model

// ==== test/tb_ees_i2c_slave.sv ====
// Self-checking bench for the serial EEPROM target.
// Assumes the master model and the bound checker in this folder.
`timescale 1ns/100ps
module tb_ees_i2c_slave;
	// ====================
	// Signals and instances
	// ====================
	localparam int WCYC = 200;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wp = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic ack, scl, msda, oe, sdo, busy, stby, r;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	wire logic sda = msda & ~oe;
	ees_i2c_slave #(.WRITE_CYCLES(WCYC)) ees_i2c_slave_inst (
		.CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sdo), .SDA_OE_O(oe),
		.CHIP_SELECT_PINS_I(3'h5), .WRITE_PROTECT_PIN_I(wp),
		.BUSY_O(busy), .STANDBY_O(stby), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat),
		.DAT_O(rdat), .ACK_O(ack)
	);
	ees_master_model mst (.clk_i(clk), .sda_i(sda), .scl_o(scl),
		.sda_o(msda));
	always #20 clk = ~clk;
	// ====================
	// Tasks
	// ====================
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			report_and_stop();
		end
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask : w
	task automatic chk_val(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk_val
	task automatic chk_bit(input string n, input logic e, g);
		chk_val(n, {31'h0, e}, {31'h0, g});
	endtask : chk_bit
	task automatic wb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		if (!wr)
			chk_val("register", e, rdat);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic sb(input logic [7:0] b, input logic e);
		logic a;
		mst.wbyte(b, a);
		chk_bit("ack", e, a);
	endtask : sb
	task automatic hdr(input logic [7:0] dv, input logic [15:0] a);
		mst.start_c();
		sb(dv, 1'b0);
		sb(a[15:8], 1'b0);
		sb(a[7:0], 1'b0);
	endtask : hdr
	task automatic rb(input logic nk, input logic [7:0] e);
		logic [7:0] d;
		mst.rbyte(nk, d);
		chk_val("byte", {24'h0, e}, {24'h0, d});
	endtask : rb
	task automatic rdx(input logic [7:0] dv, input logic [7:0] e);
		mst.start_c();
		sb(dv, 1'b0);
		rb(1'b1, e);
		mst.stop_c();
		w(6);
		chk_bit("standby", 1'b1, stby);
	endtask : rdx
	task automatic end_wr(input logic eb);
		mst.stop_c();
		w(4);
		chk_bit("busy", eb, busy);
		if (eb)
		begin
			mst.start_c();
			sb(8'haa, 1'b1);
			mst.stop_c();
		end
		while (busy !== 1'b0)
			w(1);
		w(2);
		if (eb)
			chk_bit("standby", 1'b1, stby);
	endtask : end_wr
	task automatic note(input string s);
		$display("test %s done, mismatches %0d", s, fails);
	endtask : note
	// ====================
	// Test sequence
	// ====================
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		w(3);
		wb(1'b0, 8'h00, 32'h0, 32'h1);
		wb(1'b1, 8'h04, 32'hff, 32'h0);
		wb(1'b0, 8'h04, 32'h0, 32'h4);
		wb(1'b0, 8'h08, 32'h0, 32'h0);
		wb(1'b1, 8'h00, 32'h0, 32'h0);
		wb(1'b0, 8'h00, 32'h0, 32'h0);
		mst.start_c();
		sb(8'haa, 1'b1);
		mst.stop_c();
		wb(1'b1, 8'h00, 32'h1, 32'h0);
		note("registers");
		hdr(8'haa, 16'h127f);
		sb(8'h11, 1'b0);
		sb(8'h22, 1'b0);
		sb(8'h33, 1'b0);
		end_wr(1'b1);
		hdr(8'haa, 16'h127f);
		rdx(8'hab, 8'h11);
		hdr(8'haa, 16'h1200);
		mst.stop_c();
		mst.start_c();
		sb(8'hab, 1'b0);
		rb(1'b0, 8'h22);
		rb(1'b1, 8'h33);
		mst.stop_c();
		note("array");
		wp <= 1'b1;
		hdr(8'haa, 16'h1201);
		sb(8'h99, 1'b0);
		end_wr(1'b0);
		wp <= 1'b0;
		hdr(8'haa, 16'h1201);
		rdx(8'hab, 8'h33);
		mst.start_c();
		sb(8'ha0, 1'b1);
		mst.stop_c();
		note("protect");
		hdr(8'hba, 16'h0005);
		sb(8'h5a, 1'b0);
		end_wr(1'b1);
		hdr(8'hba, 16'h0005);
		sb(8'h77, 1'b0);
		mst.start_c();
		mst.stop_c();
		hdr(8'hba, 16'h0400);
		sb(8'h02, 1'b0);
		end_wr(1'b1);
		wb(1'b0, 8'h04, 32'h0, 32'h6);
		hdr(8'hba, 16'h0005);
		sb(8'h77, 1'b1);
		mst.stop_c();
		hdr(8'hba, 16'h0005);
		rdx(8'hbb, 8'h5a);
		note("identification");
		hdr(8'haa, 16'h1200);
		mst.stop_c();
		mst.start_c();
		sb(8'hab, 1'b0);
		repeat (9) mst.xbit(1'b1, r);
		mst.start_c();
		mst.stop_c();
		hdr(8'haa, 16'h1200);
		mst.stop_c();
		note("recovery");
		report_and_stop();
	end
endmodule : tb_ees_i2c_slave
